// [hdl/display_data_pkg.sv]
package display_data_pkg;

   // ****************************************************************
   // Register map (byte addresses on the Wishbone bus)
   // ****************************************************************
   localparam logic [4:0] ADDR_CTRL   = 5'h00;
   localparam logic [4:0] ADDR_STATUS = 5'h04;
   localparam logic [4:0] ADDR_DATA   = 5'h08;
   localparam logic [4:0] ADDR_DEFL   = 5'h0C;
   localparam logic [4:0] ADDR_CMD    = 5'h10;
   localparam logic [7:0] CTRL_RESET  = 8'h00;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int CTRL_CHAR_MODE   = 0;
   localparam int CTRL_GRAPH_MODE  = 1;
   localparam int CTRL_XFER_MODE   = 2;
   localparam int CTRL_GRAPH_ORDER = 3;
   localparam int CTRL_WRITE_CMD   = 4;
   localparam int CTRL_RDCUR_CMD   = 5;
   localparam int CTRL_NO_INTR     = 6;
   localparam int CTRL_TESTIO_CMD  = 7;

   // ****************************************************************
   // Byte bit positions (bus bit 0 is the most significant bit)
   // ****************************************************************
   localparam int ST_ATTN  = 7;
   localparam int ST_BUSY  = 4;
   localparam int ST_CHEND = 3;
   localparam int ST_DEVEND = 2;
   localparam int ST_UCHK  = 1;
   localparam int S1_REJECT = 7;
   localparam int S1_WBPAR  = 5;
   localparam int S1_RGPAR  = 3;
   localparam int S1_REGEN  = 1;
   localparam int S2_PEN    = 7;
   localparam int S2_ENDORD = 6;
   localparam int S2_CHGEN  = 5;
   localparam int CURSOR_BIT = 0;

   // ****************************************************************
   // Widths, codes and timing
   // ****************************************************************
   localparam int         DEFL_W      = 10;
   localparam int         BAC_W       = 14;
   localparam logic [7:0] CURSOR_CODE = 8'h1A;
   localparam int         CLK_MHZ     = 100;
   localparam int         CMD_DLY_NS  = 245;
   localparam int         RDCUR_DLY_NS = 250;
   localparam int CMD_DLY_CYC   = (CMD_DLY_NS * CLK_MHZ + 999) / 1000;
   localparam int RDCUR_DLY_CYC = (RDCUR_DLY_NS * CLK_MHZ + 999) / 1000;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic tp1;
      logic tp6;
      logic tp9;
      logic tp10;
      logic tp11;
      logic tp12;
      logic tp15;
      logic tp16;
      logic tp19;
      logic tp21;
      logic cycEnd;
      logic proceedC;
      logic period3;
   } tp_t;

   typedef struct packed {
      logic       cmdOut;
      logic       serviceOut;
      logic       selectOut;
      logic       suppressOut;
      logic [7:0] busOut;
      logic       busOutPar;
   } chan_in_t;

   typedef struct packed {
      logic [7:0] busIn;
      logic       busInPar;
      logic       statusValid;
      logic       endingSeq;
      logic       continueSvc;
      logic       cmdStrobe;
      logic [7:0] cmdByte;
   } chan_out_t;

endpackage

// [hdl/display_data_register_path.sv]
// The address map and the Wishbone slave port are this design's own decisions.
module display_data_register_path #(
   parameter int CHAR_SPACE = 10,
   parameter int LINE_SPACE = 16
) (
   input  wire logic                                  sys_clk,
   input  wire logic                                  rst_n,
   input  wire logic                                  cyc_i,
   input  wire logic                                  stb_i,
   input  wire logic                                  we_i,
   input  wire logic [4:0]                            adr_i,
   input  wire logic [3:0]                            sel_i,
   input  wire logic [31:0]                           dat_i,
   output      logic [31:0]                           dat_o,
   output      logic                                  ack_o,
   input  wire display_data_pkg::tp_t                 tp,
   input  wire display_data_pkg::chan_in_t            chanIn,
   output      display_data_pkg::chan_out_t           chanOut,
   input  wire logic                                  statusInEarly,
   input  wire logic                                  channelRequest,
   input  wire logic                                  addressInEarly,
   input  wire logic                                  unitBusy,
   input  wire logic                                  attnEvent,
   input  wire logic                                  chEndEvent,
   input  wire logic                                  devEndEvent,
   input  wire logic                                  unitChkEvent,
   input  wire logic                                  regenActive,
   input  wire logic                                  senseStart,
   input  wire logic                                  senseStep,
   input  wire logic                                  cmdReject,
   input  wire logic                                  wbufParErr,
   input  wire logic                                  regenParErr,
   input  wire logic                                  penHit,
   input  wire logic                                  manualInput,
   input  wire logic                                  endOrderSeq,
   input  wire logic                                  keyActive,
   input  wire logic                                  nullCode,
   input  wire logic [7:0]                            keyCode,
   input  wire logic                                  keyCodePar,
   input  wire logic                                  clrCursor,
   input  wire logic                                  setCursor,
   input  wire logic                                  cursorFound,
   input  wire logic                                  remember7,
   input  wire logic [2:0]                            byteCount,
   input  wire logic                                  charAdvance,
   input  wire logic                                  lineAdvance,
   input  wire logic [display_data_pkg::BAC_W-1:0]    bufAddrCount,
   input  wire logic                                  bufRdValid,
   input  wire logic [7:0]                            bufRdData,
   input  wire logic                                  bufRdPar,
   output      logic [display_data_pkg::BAC_W-1:0]    bufAddrLatch,
   output      logic                                  startRead,
   output      logic                                  cursorOperate,
   output      logic                                  timing_pulse_26,
   output      logic                                  tp7Req,
   output      logic                                  decLatch,
   output      logic                                  insertLatch,
   output      logic                                  stepBac,
   output      logic [display_data_pkg::DEFL_W-1:0]   xDefl,
   output      logic [display_data_pkg::DEFL_W-1:0]   yDefl,
   output      logic [7:0]                            charCode
);
   import display_data_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [3:0]        tag1;
      logic [3:0]        tag2;
      logic [3:0]        tag3;
      logic [8:0]        bo1;
      logic [8:0]        bo2;
      logic [8:0]        bo3;
      logic [3:0]        tagQ;
      logic [8:0]        boQ;
      logic [7:0]        cmdDly;
      logic [7:0]        bReg;
      logic              bPar;
      logic [7:0]        aReg;
      logic [7:0]        asmReg;
      logic [DEFL_W-1:0] xDef;
      logic [DEFL_W-1:0] yDef;
      logic              attn;
      logic              chEnd;
      logic              devEnd;
      logic              unitChk;
      logic              adapterReq;
      logic              inhibit;
      logic              srvPrev;
      logic [1:0]        senseIdx;
      logic              tp26Pend;
      logic              tp26Cyc;
      logic [4:0]        rcCnt;
      logic              rcWait;
      logic [7:0]        ctrl;
      logic [31:0]       rdData;
      logic              ack;
      chan_out_t         co;
      logic [BAC_W-1:0]  bal;
      logic              startRd;
      logic              cursorOp;
      logic              tp26Pulse;
      logic              tp7Pulse;
      logic              decL;
      logic              insL;
      logic              stepB;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   function automatic logic oddPar(input logic [7:0] d);
      oddPar = ~^d;
   endfunction

   function automatic logic [7:0] statusByte(input state_t s, input logic showBusy,
                                             input logic inh);
      logic [7:0] b;
      b = 8'h00;
      b[ST_ATTN]   = s.attn & ~inh;
      b[ST_CHEND]  = s.chEnd & ~inh;
      b[ST_DEVEND] = s.devEnd & ~inh;
      b[ST_UCHK]   = s.unitChk & ~inh;
      b[ST_BUSY]   = showBusy;
      statusByte = b;
   endfunction

   logic       busyInh;
   logic       showBusy;
   logic       srvRise;
   logic       cmdGate;
   logic       accept;
   logic [7:0] stByte;
   logic [7:0] senseByte;
   logic       wbReq;
   logic       activeMode;

   always_comb begin
      st_nxt = st_r;
      busyInh = 1'b0;
      showBusy = 1'b0;
      srvRise = 1'b0;
      cmdGate = 1'b0;
      accept = 1'b0;
      stByte = 8'h00;
      senseByte = 8'h00;
      wbReq = 1'b0;
      activeMode = 1'b0;

      // ****************************************************************
      // Pin synchronisers: a change counts once stages two and three agree
      // ****************************************************************
      st_nxt.tag1 = {chanIn.cmdOut, chanIn.serviceOut, chanIn.selectOut, chanIn.suppressOut};
      st_nxt.tag2 = st_r.tag1;
      st_nxt.tag3 = st_r.tag2;
      st_nxt.bo1 = {chanIn.busOut, chanIn.busOutPar};
      st_nxt.bo2 = st_r.bo1;
      st_nxt.bo3 = st_r.bo2;
      for (int i = 0; i < 4; i++) begin
         if (st_r.tag2[i] == st_r.tag3[i]) begin
            st_nxt.tagQ[i] = st_r.tag3[i];
         end
      end
      if (st_r.bo2 == st_r.bo3) begin
         st_nxt.boQ = st_r.bo3;
      end

      // Pulses last one cycle
      st_nxt.startRd = 1'b0;
      st_nxt.tp26Pulse = 1'b0;
      st_nxt.tp7Pulse = 1'b0;
      st_nxt.stepB = 1'b0;
      st_nxt.co.cmdStrobe = 1'b0;
      st_nxt.ack = 1'b0;

      // ****************************************************************
      // Cursor and keyboard sequencing
      // ****************************************************************
      if (tp.tp1 && st_r.ctrl[CTRL_CHAR_MODE] && keyActive && st_r.bReg[CURSOR_BIT]) begin
         st_nxt.cursorOp = 1'b1;
         st_nxt.tp26Pend = 1'b1;
      end
      if (tp.cycEnd && st_r.tp26Pend) begin
         st_nxt.tp26Pulse = 1'b1;
         st_nxt.tp26Pend = 1'b0;
         st_nxt.tp26Cyc = 1'b1;
      end
      if (st_r.tp26Cyc && tp.tp19) begin
         st_nxt.decL = 1'b1;
         st_nxt.insL = 1'b1;
      end
      if (st_r.tp26Cyc && tp.tp10) begin
         st_nxt.stepB = 1'b1;
      end
      if (st_r.tp26Cyc && tp.cycEnd && !st_r.tp26Pend) begin
         st_nxt.tp7Pulse = 1'b1;
         st_nxt.tp26Cyc = 1'b0;
         st_nxt.decL = 1'b0;
         st_nxt.cursorOp = 1'b0;
      end
      if (tp.tp12) begin
         st_nxt.insL = 1'b0;
      end

      // ****************************************************************
      // Buffer data register; later loads override clears in one cycle
      // ****************************************************************
      if (tp.tp9) begin
         st_nxt.bReg = 8'h00;
         st_nxt.bPar = 1'b0;
         st_nxt.bal = bufAddrCount;
         st_nxt.startRd = 1'b1;
      end
      if (bufRdValid) begin
         st_nxt.bReg = bufRdData;
         st_nxt.bPar = bufRdPar;
      end
      if (tp.tp10 && st_r.insL && !nullCode) begin
         st_nxt.bReg = 8'h00;
         st_nxt.bPar = 1'b0;
      end
      if (tp.tp11 && st_r.insL && !nullCode) begin
         st_nxt.bReg = keyCode;
         st_nxt.bPar = keyCodePar;
      end
      if (tp.tp11 && (clrCursor || setCursor)) begin
         st_nxt.bReg[CURSOR_BIT] = ~st_r.bReg[CURSOR_BIT];
         st_nxt.bPar = ~st_r.bPar;
      end
      if (tp.tp15) begin
         st_nxt.bReg = 8'h00;
         st_nxt.bPar = 1'b0;
      end
      if (tp.tp16) begin
         st_nxt.bReg = st_r.aReg;
         st_nxt.bPar = oddPar(st_r.aReg);
      end
      // Double-line transfer overwrites every bit, so no clear is needed
      if (st_r.ctrl[CTRL_WRITE_CMD] && tp.period3) begin
         st_nxt.bReg = st_r.boQ[8:1];
         st_nxt.bPar = st_r.boQ[0];
      end
      if (st_r.ctrl[CTRL_RDCUR_CMD] && cursorFound) begin
         st_nxt.bReg = 8'h00;
         st_nxt.bPar = 1'b0;
         st_nxt.rcWait = 1'b1;
         st_nxt.rcCnt = 5'h00;
      end else if (st_r.rcWait) begin
         if (st_r.rcCnt == 5'(RDCUR_DLY_CYC - 1)) begin
            st_nxt.bReg = CURSOR_CODE;
            st_nxt.bPar = oddPar(CURSOR_CODE);
            st_nxt.rcWait = 1'b0;
         end else begin
            st_nxt.rcCnt = st_r.rcCnt + 5'h01;
         end
      end

      // ****************************************************************
      // Holding, assembly and deflection registers
      // ****************************************************************
      activeMode = st_r.ctrl[CTRL_GRAPH_MODE] | st_r.ctrl[CTRL_CHAR_MODE]
                 | st_r.ctrl[CTRL_XFER_MODE];
      if (tp.proceedC && activeMode) begin
         st_nxt.aReg = st_r.bReg;
      end
      if ((tp.tp12 || tp.tp21) && remember7 && (st_r.bPar == oddPar(st_r.bReg))) begin
         st_nxt.aReg = st_r.bReg;
      end
      if (tp.proceedC && st_r.ctrl[CTRL_GRAPH_ORDER] && byteCount == 3'h1) begin
         st_nxt.asmReg = st_r.bReg;
      end
      if (tp.tp6) begin
         st_nxt.xDef = {st_r.asmReg[DEFL_W-9:0], st_r.aReg};
         st_nxt.yDef = {st_r.asmReg[7:16-DEFL_W], st_r.bReg};
      end else begin
         if (charAdvance) begin
            st_nxt.xDef = st_r.xDef + DEFL_W'(CHAR_SPACE);
         end
         if (lineAdvance) begin
            st_nxt.yDef = st_r.yDef - DEFL_W'(LINE_SPACE);
         end
      end

      // ****************************************************************
      // Command capture
      // ****************************************************************
      if (st_r.tagQ[3]) begin
         if (st_r.cmdDly != 8'(CMD_DLY_CYC)) begin
            st_nxt.cmdDly = st_r.cmdDly + 8'h01;
         end
      end else begin
         st_nxt.cmdDly = 8'h00;
      end
      // One strobe per Command Out: gate fires as the delay count completes
      cmdGate = (st_r.cmdDly == 8'(CMD_DLY_CYC - 1)) && st_r.tagQ[3] && !unitBusy
              && (^st_r.boQ) && addressInEarly && channelRequest;
      if (cmdGate) begin
         st_nxt.co.cmdByte = st_r.boQ[8:1];
         st_nxt.co.cmdStrobe = 1'b1;
      end

      // ****************************************************************
      // Status: set wins over the Service Out clear
      // ****************************************************************
      srvRise = st_r.tagQ[2] && !st_r.srvPrev;
      st_nxt.srvPrev = st_r.tagQ[2];
      busyInh = unitBusy && st_r.ctrl[CTRL_NO_INTR];
      showBusy = unitBusy && !st_r.ctrl[CTRL_TESTIO_CMD];
      stByte = statusByte(st_r, showBusy, busyInh);
      accept = srvRise && st_r.co.statusValid && !st_r.inhibit;
      if (accept) begin
         st_nxt.attn = 1'b0;
         st_nxt.chEnd = 1'b0;
         st_nxt.devEnd = 1'b0;
         st_nxt.unitChk = 1'b0;
         st_nxt.adapterReq = 1'b0;
      end
      if (srvRise) begin
         st_nxt.co.statusValid = 1'b0;
      end
      if (attnEvent) begin
         st_nxt.attn = 1'b1;
      end
      if (chEndEvent) begin
         st_nxt.chEnd = 1'b1;
      end
      if (devEndEvent) begin
         st_nxt.devEnd = 1'b1;
      end
      if (unitChkEvent) begin
         st_nxt.unitChk = 1'b1;
      end
      if (regenActive && (attnEvent || unitChkEvent)) begin
         st_nxt.adapterReq = 1'b1;
      end
      if (statusInEarly || (st_r.adapterReq && st_r.tagQ[1] && !st_r.tagQ[0])) begin
         st_nxt.co.busIn = stByte;
         st_nxt.co.busInPar = oddPar(stByte);
         st_nxt.co.statusValid = 1'b1;
         st_nxt.inhibit = busyInh;
         st_nxt.co.endingSeq = (stByte != 8'h00);
         st_nxt.co.continueSvc = (stByte == 8'h00);
      end

      // ****************************************************************
      // Sense bytes
      // ****************************************************************
      if (senseStart || senseStep) begin
         unique case (senseStart ? 2'h0 : st_r.senseIdx)
            2'h0: begin
               senseByte[S1_REJECT] = cmdReject;
               senseByte[S1_WBPAR] = wbufParErr;
               senseByte[S1_RGPAR] = regenParErr;
               senseByte[S1_REGEN] = regenActive;
            end
            2'h1: begin
               senseByte[S2_PEN] = penHit && !manualInput && !endOrderSeq;
               senseByte[S2_ENDORD] = endOrderSeq;
               senseByte[S2_CHGEN] = st_r.ctrl[CTRL_CHAR_MODE];
            end
            // Count is only meaningful while regeneration is stopped
            2'h2: senseByte = {2'b00, bufAddrCount[13:8]};
            2'h3: senseByte = bufAddrCount[7:0];
         endcase
         st_nxt.co.busIn = senseByte;
         st_nxt.co.busInPar = oddPar(senseByte);
         st_nxt.senseIdx = senseStart ? 2'h1 : st_r.senseIdx + 2'h1;
      end

      // ****************************************************************
      // Wishbone slave: one wait state, ack drops after one cycle
      // ****************************************************************
      wbReq = cyc_i && stb_i && !st_r.ack;
      if (wbReq) begin
         st_nxt.ack = 1'b1;
         st_nxt.rdData = 32'h0000_0000;
         unique case (adr_i)
            ADDR_CTRL: begin
               st_nxt.rdData = {24'h00_0000, st_r.ctrl};
               if (we_i && sel_i[0]) begin
                  st_nxt.ctrl = dat_i[7:0];
               end
            end
            ADDR_STATUS: st_nxt.rdData = {20'h0_0000, st_r.tp26Cyc, st_r.cursorOp,
                                          st_r.inhibit, st_r.adapterReq, stByte};
            ADDR_DATA:   st_nxt.rdData = {7'h00, st_r.bPar, st_r.asmReg, st_r.aReg, st_r.bReg};
            ADDR_DEFL:   st_nxt.rdData = {6'h00, st_r.yDef, 6'h00, st_r.xDef};
            ADDR_CMD:    st_nxt.rdData = {24'h00_0000, st_r.co.cmdByte};
            default:     st_nxt.rdData = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.ctrl <= CTRL_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dat_o = st_r.rdData;
   assign ack_o = st_r.ack;
   assign chanOut = st_r.co;
   assign bufAddrLatch = st_r.bal;
   assign startRead = st_r.startRd;
   assign cursorOperate = st_r.cursorOp;
   assign timing_pulse_26 = st_r.tp26Pulse;
   assign tp7Req = st_r.tp7Pulse;
   assign decLatch = st_r.decL;
   assign insertLatch = st_r.insL;
   assign stepBac = st_r.stepB;
   assign xDefl = st_r.xDef;
   assign yDefl = st_r.yDef;
   assign charCode = st_r.aReg;

endmodule

// [tb/chan_model.sv]
// ****************************************
// Host channel model
// ****************************************
module chan_model (
   input  wire logic                   sys_clk,
   output display_data_pkg::chan_in_t  chanIn
);
   timeunit 1ns;
   timeprecision 1ps;
   initial chanIn = '0;
   // Byte and odd parity on Bus Out; held long past the sync and qualify delays
   task put(input logic [7:0] b, input logic cmd);
      @(posedge sys_clk);
      chanIn.busOut <= b;
      chanIn.busOutPar <= ~^b;
      chanIn.cmdOut <= cmd;
      repeat (40) @(posedge sys_clk);
      chanIn.cmdOut <= 1'b0;
      chanIn.busOut <= ~b;
   endtask
   task accept;
      @(posedge sys_clk);
      chanIn.serviceOut <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chanIn.serviceOut <= 1'b0;
   endtask
endmodule

// [tb/display_data_props.sv]
// ****************************************
// Port checker
// ****************************************
module display_data_props (
   input wire logic                              sys_clk, rst_n, cyc_i, stb_i, ack_o,
   input wire logic                              startRead, cursorOperate, timing_pulse_26,
   input wire logic                              tp7Req, decLatch, stepBac, unitBusy,
   input wire logic                              addressInEarly, channelRequest,
   input wire logic [display_data_pkg::BAC_W-1:0] bufAddrCount, bufAddrLatch,
   input wire logic [7:0]                        charCode,
   input wire display_data_pkg::tp_t             tp,
   input wire display_data_pkg::chan_out_t       chanOut
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   ackNext_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered");
   ackPulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held too long");
   readStart_a: assert property (tp.tp9 |=> startRead && bufAddrLatch == $past(bufAddrCount))
      else $error("buffer read not started");
   readCause_a: assert property (startRead |-> $past(tp.tp9))
      else $error("stray buffer read");
   cursorPulse_a: assert property (timing_pulse_26 |-> $past(cursorOperate))
      else $error("pulse 26 without cursor latch");
   endPulse_a: assert property (tp7Req |-> $past(decLatch) && !decLatch)
      else $error("end pulse out of sequence");
   stepCause_a: assert property (stepBac |-> $past(tp.tp10))
      else $error("step without pulse 10");
   holdLoad_a: assert property ($changed(charCode) |-> $past(tp.tp12 || tp.tp21 || tp.proceedC))
      else $error("holding register loaded off time");
   cmdGate_a: assert property (chanOut.cmdStrobe |-> $past(addressInEarly && channelRequest && !unitBusy))
      else $error("command captured without gate");
endmodule
bind display_data_register_path display_data_props CHK (.*);

// [tb/tb_top.sv]
// ****************************************
// Bench top
// ****************************************
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import display_data_pkg::*;
   logic sys_clk = 0, rst_n = 0, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, startRead, cursorOperate;
   logic timing_pulse_26, tp7Req, decLatch, insertLatch, stepBac, statusInEarly = 0, unitBusy = 0;
   logic channelRequest = 1, addressInEarly = 1, attnEvent = 0, chEndEvent = 0, devEndEvent = 0;
   logic unitChkEvent = 0, regenActive = 0, senseStart = 0, senseStep = 0, cmdReject = 1;
   logic wbufParErr = 0, regenParErr = 0, penHit = 0, manualInput = 0, endOrderSeq = 0;
   logic keyActive = 0, nullCode = 0, keyCodePar = 0, clrCursor = 0, setCursor = 0, cursorFound = 0;
   logic remember7 = 0, charAdvance = 0, lineAdvance = 0, bufRdValid = 0, bufRdPar = 0;
   logic [7:0] keyCode = 8'h41, bufRdData = 8'h5A, charCode, sense [4] = '{8'h80, 8'h00, 8'h2A, 8'hBC};
   logic [4:0] adr_i = 0;
   logic [3:0] sel_i = 4'h1;
   logic [2:0] byteCount = 0;
   logic [31:0] dat_i = 0, dat_o, rd;
   logic [BAC_W-1:0] bufAddrCount = 14'h2ABC, bufAddrLatch;
   logic [DEFL_W-1:0] xDefl, yDefl;
   tp_t tp = '0;
   chan_in_t chanIn;
   chan_out_t chanOut;
   int bad_count = 0, checked = 0;
   display_data_register_path DUT (.*);
   chan_model HOST (.sys_clk(sys_clk), .chanIn(chanIn));
   initial forever #5 sys_clk = ~sys_clk;
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      do @(posedge sys_clk); while (ack_o !== 1'b1);
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask
   // One-cycle timing pulse; bit 12 is tp1 down to bit 0 period3
   task pulse(input tp_t p, input logic st);
      @(posedge sys_clk);
      tp <= p;
      statusInEarly <= st;
      @(posedge sys_clk);
      tp <= '0;
      statusInEarly <= 1'b0;
      @(posedge sys_clk);
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      wb(0, ADDR_CTRL, 0);
      cmp(rd, CTRL_RESET);
      wb(0, 5'h14, 0);
      cmp(rd, 0);
      pulse(13'h400, 0);
      cmp(bufAddrLatch, 14'h2ABC);
      bufRdValid <= 1'b1;
      wb(0, ADDR_DATA, 0);
      bufRdValid <= 1'b0;
      cmp(rd[7:0], 8'h5A);
      pulse(13'h400, 0);
      wb(0, ADDR_DATA, 0);
      cmp(rd[7:0], 8'h00);
      $display("buffer read test done");
      wb(1, ADDR_CTRL, 32'h11);
      HOST.put(8'h3D, 0);
      pulse(13'h001, 0);
      wb(0, ADDR_DATA, 0);
      cmp(rd[7:0], 8'h3D);
      keyActive <= 1'b1;
      pulse(13'h1000, 0);
      cmp(cursorOperate, 1);
      pulse(13'h004, 0);
      cmp(timing_pulse_26, 1);
      pulse(13'h010, 0);
      cmp({decLatch, insertLatch}, 2'b11);
      pulse(13'h200, 0);
      cmp(stepBac, 1);
      pulse(13'h100, 0);
      wb(0, ADDR_DATA, 0);
      cmp(rd[7:0], 8'h41);
      // Key load and cursor flip share tp11; the flip inverts bit 0 of the byte held before the load
      setCursor <= 1'b1;
      pulse(13'h100, 0);
      setCursor <= 1'b0;
      wb(0, ADDR_DATA, 0);
      cmp(rd[7:0], 8'h40);
      pulse(13'h004, 0);
      cmp(tp7Req, 1);
      wb(1, ADDR_CTRL, 32'h21);
      cursorFound <= 1'b1;
      pulse(13'h000, 0);
      cursorFound <= 1'b0;
      repeat (RDCUR_DLY_CYC + 3) @(posedge sys_clk);
      pulse(13'h002, 0);
      cmp(charCode, CURSOR_CODE);
      $display("data path test done");
      HOST.put(8'h07, 1);
      cmp(chanOut.cmdByte, 8'h07);
      unitBusy <= 1'b1;
      HOST.put(8'h52, 1);
      cmp(chanOut.cmdByte, 8'h07);
      wb(1, ADDR_CTRL, 32'h40);
      attnEvent <= 1'b1;
      pulse(13'h000, 1);
      attnEvent <= 1'b0;
      cmp(chanOut.busIn, 8'h10);
      wb(1, ADDR_CTRL, 32'h00);
      unitBusy <= 1'b0;
      pulse(13'h000, 1);
      cmp({chanOut.busIn, chanOut.endingSeq}, 9'h101);
      HOST.accept;
      cmp(chanOut.statusValid, 0);
      pulse(13'h000, 1);
      cmp({chanOut.busIn, chanOut.continueSvc}, 9'h001);
      $display("channel test done");
      for (int i = 0; i < 4; i++) begin
         // One-cycle strobe: a longer senseStep would step the byte index again
         {senseStart, senseStep} <= (i == 0) ? 2'b10 : 2'b01;
         @(posedge sys_clk);
         {senseStart, senseStep} <= 2'b00;
         @(posedge sys_clk);
         cmp(chanOut.busIn, sense[i]);
      end
      $display("sense test done");
      report_and_stop;
   end
   initial begin
      #50us;
      bad_count++;
      report_and_stop;
   end
endmodule
